// ===== audio_tx_status_flags.sv
// Purpose: Transmit status flag bank with interrupt enable and AXI4-Lite access
// Assumes: Event inputs other than frame sync come from logic on i_clk
// Notes:   Flag set by hardware always beats a software clear in the same cycle
//
// Operation
// - A hardware set in the clearing cycle wins; flag stays set.
// - A set that beats a clear raises a fresh interrupt request.
// - Bit 8 reads OR of underflow, early sync, clock fail, port error.
// - Port error flag sets when slot port writes exceed transmitter count.
// - Software clears flags only by writing one; zero leaves them alone.
// - Interrupt asserts while a flag and its enable are both set.
// - Frame start flag sets on each new transmit frame sync.
// - Buffer empty flag sets on buffer-to-shifter move; buffer write clears it.
// - Buffer empty flag also sets on serializer reset release.
// - Every buffer empty set raises the DMA request regardless of enables.
// - Final slot flag sets with buffer empty flag on a load in the last slot.
// - Bit 3 reads the slot counter least significant bit.
// - Bits 31 to 9 read zero; writes there are ignored.
// - Underflow flag sets when shifter loads an unrefilled buffer.
// - Early sync flag sets when frame sync arrives too soon.
// - Clock fail flag sets when the clock detector reports error.
// - Enable one passes its event to the interrupt; zero blocks it.

`timescale 1ns/100ps

module audio_tx_status_flags
    import tx_status_pkg::*;
(
    input  wire logic                           i_clk,
    input  wire logic                           i_resetn,
    // AXI4-Lite slave
    input  wire logic [tx_status_pkg::ADDR_W-1:0] i_s_axi_awaddr,
    input  wire logic                           i_s_axi_awvalid,
    output logic                                o_s_axi_awready,
    input  wire logic [tx_status_pkg::DATA_W-1:0] i_s_axi_wdata,
    input  wire logic [3:0]                     i_s_axi_wstrb,
    input  wire logic                           i_s_axi_wvalid,
    output logic                                o_s_axi_wready,
    output logic [1:0]                          o_s_axi_bresp,
    output logic                                o_s_axi_bvalid,
    input  wire logic                           i_s_axi_bready,
    input  wire logic [tx_status_pkg::ADDR_W-1:0] i_s_axi_araddr,
    input  wire logic                           i_s_axi_arvalid,
    output logic                                o_s_axi_arready,
    output logic [tx_status_pkg::DATA_W-1:0]    o_s_axi_rdata,
    output logic [1:0]                          o_s_axi_rresp,
    output logic                                o_s_axi_rvalid,
    input  wire logic                           i_s_axi_rready,
    // Event sources from the transmit section
    input  wire logic                           i_tx_frame_sync,
    input  wire logic                           i_tx_early_sync,
    input  wire logic                           i_tx_clock_fail,
    input  wire logic                           i_tx_shift_load,
    input  wire logic                           i_tx_buffer_write,
    input  wire logic                           i_tx_serializer_release,
    input  wire logic                           i_tx_final_slot,
    input  wire logic                           i_tx_slot_counter_lsb,
    input  wire logic                           i_tx_slot_boundary,
    input  wire logic                           i_tx_port_write,
    input  wire logic [4:0]                     i_tx_transmitter_count,
    // Requests
    output logic                                o_tx_interrupt,
    output logic                                o_tx_interrupt_request,
    output logic                                o_tx_dma_request
);

    import tx_status_pkg::*;

    // ==========================================================
    // Declarations
    logic [ADDR_W-1:0]  wr_addr_q;
    logic               wr_addr_held_q;
    logic [DATA_W-1:0]  wr_data_q;
    logic [3:0]         wr_strb_q;
    logic               wr_data_held_q;
    logic               wr_fire;
    logic               wr_status;
    logic               wr_enable;
    logic [7:0]         flags_q;
    logic [7:0]         flags_d;
    logic [7:0]         enable_q;
    logic [7:0]         enable_st;
    logic [7:0]         set_ev;
    logic [7:0]         sw_clear;
    logic [7:0]         hw_clear;
    logic               sync_level;
    logic               sync_level_q;
    logic               refilled_q;
    logic [5:0]         port_count_q;
    logic               port_excess;
    logic [DATA_W-1:0]  status_word;

    // ==========================================================
    // Helpers

    // Moves enable bits into the status bit layout
    function automatic logic [7:0] enable_to_status(input logic [7:0] en);
        logic [7:0] st;
        st                    = 8'h00;
        st[ST_UNDERFLOW]      = en[EN_UNDERFLOW];
        st[ST_EARLY_SYNC]     = en[EN_EARLY_SYNC];
        st[ST_CLOCK_FAIL]     = en[EN_CLOCK_FAIL];
        st[ST_FINAL_SLOT]     = en[EN_FINAL_SLOT];
        st[ST_BUFFER_EMPTY]   = en[EN_BUFFER_EMPTY];
        st[ST_FRAME_START]    = en[EN_FRAME_START];
        st[ST_PORT_WRITE_ERR] = en[EN_PORT_WRITE_ERR];
        return st;
    endfunction

    // Any error flag in the status layout
    function automatic logic error_summary(input logic [7:0] f);
        return f[ST_UNDERFLOW] | f[ST_EARLY_SYNC] | f[ST_CLOCK_FAIL] | f[ST_PORT_WRITE_ERR];
    endfunction

    // ==========================================================
    // Frame sync pin
    pin_sync3 i_pin_sync3 (
        .i_clk    (i_clk),
        .i_resetn (i_resetn),
        .i_pin    (i_tx_frame_sync),
        .o_level  (sync_level)
    );

    // Previous filtered level for edge detection
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            sync_level_q <= 1'b0;
        end else begin
            sync_level_q <= sync_level;
        end
    end

    // ==========================================================
    // AXI write channel

    // Address accepted once; held until the write is performed
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            wr_addr_q      <= '0;
            wr_addr_held_q <= 1'b0;
        end else if (i_s_axi_awvalid && o_s_axi_awready) begin
            wr_addr_q      <= i_s_axi_awaddr;
            wr_addr_held_q <= 1'b1;
        end else if (wr_fire) begin
            wr_addr_held_q <= 1'b0;
        end
    end

    // Data accepted independently of the address
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            wr_data_q      <= '0;
            wr_strb_q      <= 4'h0;
            wr_data_held_q <= 1'b0;
        end else if (i_s_axi_wvalid && o_s_axi_wready) begin
            wr_data_q      <= i_s_axi_wdata;
            wr_strb_q      <= i_s_axi_wstrb;
            wr_data_held_q <= 1'b1;
        end else if (wr_fire) begin
            wr_data_held_q <= 1'b0;
        end
    end

    // Ready only while the slot is free, so one write is in flight
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_s_axi_awready <= 1'b0;
            o_s_axi_wready  <= 1'b0;
        end else begin
            o_s_axi_awready <= !wr_addr_held_q && !(i_s_axi_awvalid && o_s_axi_awready) && !o_s_axi_bvalid;
            o_s_axi_wready  <= !wr_data_held_q && !(i_s_axi_wvalid && o_s_axi_wready) && !o_s_axi_bvalid;
        end
    end

    // Both halves present: perform the write this cycle
    assign wr_fire   = wr_addr_held_q && wr_data_held_q && !o_s_axi_bvalid;
    assign wr_status = wr_fire && (wr_addr_q == OFS_TX_STATUS) && wr_strb_q[0];
    assign wr_enable = wr_fire && (wr_addr_q == OFS_TX_INT_ENABLE) && wr_strb_q[0];

    // Write response; unmapped addresses answer SLVERR
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_s_axi_bvalid <= 1'b0;
            o_s_axi_bresp  <= RESP_OKAY;
        end else if (wr_fire) begin
            o_s_axi_bvalid <= 1'b1;
            o_s_axi_bresp  <= (wr_addr_q == OFS_TX_STATUS || wr_addr_q == OFS_TX_INT_ENABLE) ?
                              RESP_OKAY : RESP_SLVERR;
        end else if (i_s_axi_bready) begin
            o_s_axi_bvalid <= 1'b0;
        end
    end

    // ==========================================================
    // Interrupt enable register

    // Reserved enable bit and upper bytes stay zero
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            enable_q <= ENABLE_RESET;
        end else if (wr_enable) begin
            enable_q <= wr_data_q[7:0] & ENABLE_WR_MASK;
        end
    end

    assign enable_st = enable_to_status(enable_q);

    // ==========================================================
    // Event detection

    // Refill tracking: a buffer write since the last load or serializer release counts
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            refilled_q <= 1'b0;
        end else if (i_tx_buffer_write) begin
            refilled_q <= 1'b1;
        end else if (i_tx_shift_load || i_tx_serializer_release) begin
            refilled_q <= 1'b0;
        end
    end

    // Port writes in the current slot versus transmitters configured
    assign port_excess = i_tx_port_write &&
                         (i_tx_slot_boundary ? (i_tx_transmitter_count == 5'h00)
                                             : (port_count_q >= {1'b0, i_tx_transmitter_count}));

    // Saturating count restarts at each slot boundary
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            port_count_q <= PORT_COUNT_RESET;
        end else if (i_tx_slot_boundary) begin
            port_count_q <= {5'h00, i_tx_port_write};
        end else if (i_tx_port_write && port_count_q != 6'h3F) begin
            port_count_q <= port_count_q + 6'h01;
        end
    end

    // Hardware set vector in status layout
    always_comb begin
        set_ev                    = 8'h00;
        set_ev[ST_UNDERFLOW]      = i_tx_shift_load && !refilled_q;
        set_ev[ST_EARLY_SYNC]     = i_tx_early_sync;
        set_ev[ST_CLOCK_FAIL]     = i_tx_clock_fail;
        set_ev[ST_BUFFER_EMPTY]   = i_tx_shift_load || i_tx_serializer_release;
        set_ev[ST_FINAL_SLOT]     = i_tx_shift_load && i_tx_final_slot;
        set_ev[ST_FRAME_START]    = sync_level && !sync_level_q;
        set_ev[ST_PORT_WRITE_ERR] = port_excess;
    end

    // ==========================================================
    // Flag register

    // Only ones written clear; the parity position is never stored
    assign sw_clear = wr_status ? (wr_data_q[7:0] & FLAG_W1C_MASK) : 8'h00;

    // Filling the buffer withdraws the buffer empty indication
    always_comb begin
        hw_clear                  = 8'h00;
        hw_clear[ST_BUFFER_EMPTY] = i_tx_buffer_write;
    end

    // Set is ORed last, so it beats any clear in the same cycle
    assign flags_d = ((flags_q & ~sw_clear & ~hw_clear) | set_ev) & FLAG_W1C_MASK;

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            flags_q <= FLAGS_RESET;
        end else begin
            flags_q <= flags_d;
        end
    end

    // ==========================================================
    // Interrupt and DMA outputs

    // Level follows the next flag state so it lines up with flags_q
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_tx_interrupt <= 1'b0;
        end else begin
            o_tx_interrupt <= |(flags_d & enable_st);
        end
    end

    // Fresh request on every enabled set, even one that beat a clear
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_tx_interrupt_request <= 1'b0;
        end else begin
            o_tx_interrupt_request <= |(set_ev & enable_st);
        end
    end

    // DMA ignores the enables; request is high the cycle after each buffer empty set
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_tx_dma_request <= 1'b0;
        end else begin
            o_tx_dma_request <= set_ev[ST_BUFFER_EMPTY];
        end
    end

    // ==========================================================
    // AXI read channel

    // Summary and parity are live, not stored
    always_comb begin
        status_word                   = '0;
        status_word[7:0]              = flags_q;
        status_word[ST_SLOT_PARITY]   = i_tx_slot_counter_lsb;
        status_word[ST_ERROR_SUMMARY] = error_summary(flags_q);
    end

    // One read at a time; arready drops while data waits
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_s_axi_arready <= 1'b0;
        end else begin
            o_s_axi_arready <= !o_s_axi_rvalid && !(i_s_axi_arvalid && o_s_axi_arready);
        end
    end

    // Read data captured at address acceptance
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_s_axi_rvalid <= 1'b0;
            o_s_axi_rdata  <= '0;
            o_s_axi_rresp  <= RESP_OKAY;
        end else if (i_s_axi_arvalid && o_s_axi_arready) begin
            o_s_axi_rvalid <= 1'b1;
            unique case (i_s_axi_araddr)
                OFS_TX_STATUS: begin
                    o_s_axi_rdata <= status_word;
                    o_s_axi_rresp <= RESP_OKAY;
                end
                OFS_TX_INT_ENABLE: begin
                    o_s_axi_rdata <= {24'h000000, enable_q};
                    o_s_axi_rresp <= RESP_OKAY;
                end
                default: begin
                    o_s_axi_rdata <= '0;
                    o_s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end else if (i_s_axi_rready) begin
            o_s_axi_rvalid <= 1'b0;
        end
    end

endmodule // audio_tx_status_flags

// ===== tx_status_pkg.sv
// Purpose: Shared constants for the transmit status flag bank
// Assumes: 32-bit AXI4-Lite register bus, byte addresses as printed
// Notes:   Status and enable registers use different bit layouts

package tx_status_pkg;

    // ==========================================================
    // Bus geometry
    localparam int          ADDR_W              = 8;
    localparam int          DATA_W              = 32;

    // ==========================================================
    // Register byte offsets
    localparam logic [7:0]  OFS_TX_INT_ENABLE   = 8'hBC;
    localparam logic [7:0]  OFS_TX_STATUS       = 8'hC0;

    // ==========================================================
    // Status register bit positions
    localparam int          ST_UNDERFLOW        = 0;
    localparam int          ST_EARLY_SYNC       = 1;
    localparam int          ST_CLOCK_FAIL       = 2;
    localparam int          ST_SLOT_PARITY      = 3;
    localparam int          ST_FINAL_SLOT       = 4;
    localparam int          ST_BUFFER_EMPTY     = 5;
    localparam int          ST_FRAME_START      = 6;
    localparam int          ST_PORT_WRITE_ERR   = 7;
    localparam int          ST_ERROR_SUMMARY    = 8;

    // ==========================================================
    // Interrupt enable register bit positions
    localparam int          EN_UNDERFLOW        = 0;
    localparam int          EN_EARLY_SYNC       = 1;
    localparam int          EN_CLOCK_FAIL       = 2;
    localparam int          EN_PORT_WRITE_ERR   = 3;
    localparam int          EN_FINAL_SLOT       = 4;
    localparam int          EN_BUFFER_EMPTY     = 5;
    localparam int          EN_FRAME_START      = 7;

    // ==========================================================
    // Writable masks and reset values
    localparam logic [7:0]  FLAG_W1C_MASK       = 8'hF7;
    localparam logic [7:0]  ENABLE_WR_MASK      = 8'hBF;
    localparam logic [7:0]  FLAGS_RESET         = 8'h00;
    localparam logic [7:0]  ENABLE_RESET        = 8'h00;
    localparam logic [5:0]  PORT_COUNT_RESET    = 6'h00;

    // ==========================================================
    // AXI responses
    localparam logic [1:0]  RESP_OKAY           = 2'h0;
    localparam logic [1:0]  RESP_SLVERR         = 2'h2;

endpackage

// ===== pin_sync3.sv
// Purpose: Three-stage synchroniser for one asynchronous pin level
// Assumes: Input may change at any time relative to i_clk
// Notes:   Output moves only when stages two and three agree

`timescale 1ns/100ps

module pin_sync3 (
    input  wire logic   i_clk,
    input  wire logic   i_resetn,
    input  wire logic   i_pin,
    output logic        o_level
);

    logic   meta_q;
    logic   stage2_q;
    logic   stage3_q;

    // ==========================================================
    // Sync chain; first stage feeds only the second
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            meta_q   <= 1'b0;
            stage2_q <= 1'b0;
            stage3_q <= 1'b0;
        end else begin
            meta_q   <= i_pin;
            stage2_q <= meta_q;
            stage3_q <= stage2_q;
        end
    end

    // Agreement filter rejects single-stage disagreement
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_level <= 1'b0;
        end else if (stage2_q == stage3_q) begin
            o_level <= stage3_q;
        end
    end

endmodule // pin_sync3

// ===== tx_flags_monitor.sv
// Purpose: Port-level checks for the transmit status flag bank
// Assumes: One clock domain, asynchronous active-low reset
// Notes:   Read address is latched here so status reads can be told apart
`timescale 1ns/100ps
module tx_flags_monitor
    import tx_status_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_resetn,
    input  wire logic [7:0]  i_s_axi_araddr,
    input  wire logic        i_s_axi_arvalid,
    input  wire logic        o_s_axi_arready,
    input  wire logic [31:0] o_s_axi_rdata,
    input  wire logic        o_s_axi_rvalid,
    input  wire logic        i_s_axi_rready,
    input  wire logic        o_s_axi_bvalid,
    input  wire logic        i_s_axi_bready,
    input  wire logic        i_tx_shift_load,
    input  wire logic        i_tx_serializer_release,
    input  wire logic        o_tx_dma_request
);
    logic [7:0] rd_addr_q;
    logic       st_rd;
    // ========================================
    // Read tracking
    // Remember the register behind the pending read answer
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn)
            rd_addr_q <= 8'h00;
        else if (i_s_axi_arvalid && o_s_axi_arready)
            rd_addr_q <= i_s_axi_araddr;
    end
    // Status answer on the read channel
    assign st_rd = o_s_axi_rvalid && (rd_addr_q == OFS_TX_STATUS);
    // ========================================
    // Properties
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    property p_b_hold; o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid; endproperty
    a_b_hold: assert property (p_b_hold) else $error("Write response withdrawn early");
    property p_r_hold; o_s_axi_rvalid && !i_s_axi_rready |=> o_s_axi_rvalid && $stable(o_s_axi_rdata); endproperty
    a_r_hold: assert property (p_r_hold) else $error("Read answer changed before taken");
    property p_r_answer; i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid; endproperty
    a_r_answer: assert property (p_r_answer) else $error("Read answer late");
    property p_dma_load; i_tx_shift_load |=> o_tx_dma_request; endproperty
    a_dma_load: assert property (p_dma_load) else $error("No DMA request after load");
    property p_dma_rel; i_tx_serializer_release |=> o_tx_dma_request; endproperty
    a_dma_rel: assert property (p_dma_rel) else $error("No DMA request after release");
    property p_dma_cause; o_tx_dma_request |-> $past(i_tx_shift_load) || $past(i_tx_serializer_release); endproperty
    a_dma_cause: assert property (p_dma_cause) else $error("DMA request without cause");
    property p_err_sum; st_rd |-> o_s_axi_rdata[8] == (|{o_s_axi_rdata[7], o_s_axi_rdata[2:0]}); endproperty
    a_err_sum: assert property (p_err_sum) else $error("Error summary wrong");
    property p_hi_zero; st_rd |-> o_s_axi_rdata[31:9] == 23'h0; endproperty
    a_hi_zero: assert property (p_hi_zero) else $error("Upper status bits not zero");
endmodule // tx_flags_monitor

// ===== tx_buffer_server.sv
// Purpose: Behavioural CPU or DMA that refills the transmit holding buffer
// Assumes: Each DMA request asks for one buffer write
// Notes:   A later request restarts the wait, so close loads get one refill
`timescale 1ns/100ps
module tx_buffer_server #(
    parameter int DELAY = 20
) (
    input  wire logic i_clk,
    input  wire logic i_resetn,
    input  wire logic i_dma_request,
    output logic      o_buffer_write
);
    int wait_q;
    // ========================================
    // Refill
    // Slow on purpose, so the empty flag can be seen before the refill
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            wait_q <= 0;
            o_buffer_write <= 1'b0;
        end else begin
            o_buffer_write <= (wait_q == 1);
            if (i_dma_request)
                wait_q <= DELAY;
            else if (wait_q != 0)
                wait_q <= wait_q - 1;
        end
    end
endmodule // tx_buffer_server

// ===== audio_tx_status_flags_tb.sv
// Purpose: Self-checking bench for the transmit status flag bank
// Assumes: Partner refills the buffer a fixed delay after the latest DMA request
// Notes:   Every task that drives pins first waits an edge, so no signal is driven twice at once
`timescale 1ns/100ps
module audio_tx_status_flags_tb;
    import tx_status_pkg::*;
    localparam int         REFILL  = 20;
    localparam logic [5:0] EV_ERLY = 6'h01;
    localparam logic [5:0] EV_CKF  = 6'h02;
    localparam logic [5:0] EV_LOAD = 6'h04;
    localparam logic [5:0] EV_REL  = 6'h08;
    localparam logic [5:0] EV_BND  = 6'h10;
    localparam logic [5:0] EV_PORT = 6'h20;
    logic        clk = 1'b0, resetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0, fsync = 1'b0, last = 1'b0, lsb = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, intr, dma, bwr, ireq, req_b;
    logic [1:0]  bresp, rresp, rsp;
    logic [5:0]  ev = 6'h00;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rdat;
    int          miscompares = 0, compares = 0;
    // 10 MHz clock
    always #50 clk = ~clk;
    // ========================================
    // Design and partner
    audio_tx_status_flags i_audio_tx_status_flags (
        .i_clk(clk), .i_resetn(resetn), .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid),
        .o_s_axi_awready(awready), .i_s_axi_wdata(wdata), .i_s_axi_wstrb(4'hF), .i_s_axi_wvalid(wvalid),
        .o_s_axi_wready(wready), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
        .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready), .o_s_axi_rdata(rdata),
        .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready), .i_tx_frame_sync(fsync),
        .i_tx_early_sync(ev[0]), .i_tx_clock_fail(ev[1]), .i_tx_shift_load(ev[2]), .i_tx_buffer_write(bwr),
        .i_tx_serializer_release(ev[3]), .i_tx_final_slot(last), .i_tx_slot_counter_lsb(lsb),
        .i_tx_slot_boundary(ev[4]), .i_tx_port_write(ev[5]), .i_tx_transmitter_count(5'h02),
        .o_tx_interrupt(intr), .o_tx_interrupt_request(ireq), .o_tx_dma_request(dma));
    tx_buffer_server #(.DELAY(REFILL)) i_tx_buffer_server (
        .i_clk(clk), .i_resetn(resetn), .i_dma_request(dma), .o_buffer_write(bwr));
    // ========================================
    // Tasks
    task automatic stop_test();
        if (miscompares == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Both write channels offered at once, each released when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!bvalid) begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end
        bready <= 1'b0;
        rsp = bresp;
        req_b = ireq;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!rvalid) begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end
        rready <= 1'b0;
        rdat = rdata;
        rsp = rresp;
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] exp);
        rd(a);
        chk(rdat, exp);
    endtask
    task automatic pulse(input logic [5:0] m, input int n);
        @(posedge clk);
        ev <= m;
        repeat (n) @(posedge clk);
        ev <= 6'h00;
    endtask
    // ========================================
    // Scenarios
    task automatic t_reset();
        rc(OFS_TX_STATUS, 32'h0);
        rc(OFS_TX_INT_ENABLE, 32'h0);
        lsb <= 1'b1;
        rc(OFS_TX_STATUS, 32'h8);
        wr(OFS_TX_STATUS, 32'hFFFFFFFF);
        chk({30'h0, rsp}, {30'h0, RESP_OKAY});
        rc(OFS_TX_STATUS, 32'h8);
        lsb <= 1'b0;
        rc(8'h10, 32'h0);
        chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
    endtask
    task automatic t_flags();
        pulse(EV_ERLY, 1);
        rc(OFS_TX_STATUS, 32'h102);
        chk({31'h0, intr}, 32'h0);
        wr(OFS_TX_INT_ENABLE, 32'hFFFFFFFF);
        rc(OFS_TX_INT_ENABLE, 32'hBF);
        chk({31'h0, intr}, 32'h1);
        pulse(EV_CKF, 1);
        wr(OFS_TX_STATUS, 32'h0);
        rc(OFS_TX_STATUS, 32'h106);
        wr(OFS_TX_STATUS, 32'h2);
        chk({31'h0, req_b}, 32'h0);
        rc(OFS_TX_STATUS, 32'h104);
        ev <= EV_ERLY;
        wr(OFS_TX_STATUS, 32'h6);
        ev <= 6'h00;
        chk({31'h0, req_b}, 32'h1);
        rc(OFS_TX_STATUS, 32'h102);
        chk({31'h0, intr}, 32'h1);
        wr(OFS_TX_STATUS, 32'h2);
        rc(OFS_TX_STATUS, 32'h0);
        chk({31'h0, intr}, 32'h0);
        wr(OFS_TX_INT_ENABLE, 32'h0);
    endtask
    task automatic t_buffer();
        pulse(EV_REL, 1);
        rc(OFS_TX_STATUS, 32'h20);
        repeat (REFILL + 10) @(posedge clk);
        rc(OFS_TX_STATUS, 32'h0);
        last <= 1'b1;
        pulse(EV_LOAD, 1);
        last <= 1'b0;
        rc(OFS_TX_STATUS, 32'h30);
        repeat (REFILL + 10) @(posedge clk);
        rc(OFS_TX_STATUS, 32'h10);
        pulse(EV_LOAD, 2);
        rc(OFS_TX_STATUS, 32'h131);
        repeat (REFILL + 10) @(posedge clk);
        wr(OFS_TX_STATUS, 32'hFF);
        rc(OFS_TX_STATUS, 32'h0);
    endtask
    task automatic t_port_sync();
        pulse(EV_BND | EV_PORT, 1);
        pulse(EV_PORT, 1);
        rc(OFS_TX_STATUS, 32'h0);
        pulse(EV_PORT, 1);
        rc(OFS_TX_STATUS, 32'h180);
        wr(OFS_TX_STATUS, 32'h80);
        fsync <= 1'b1;
        repeat (10) @(posedge clk);
        fsync <= 1'b0;
        repeat (10) @(posedge clk);
        rc(OFS_TX_STATUS, 32'h40);
    endtask
    // ========================================
    // Main sequence and watchdog
    initial begin
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        t_reset();
        t_flags();
        t_buffer();
        t_port_sync();
        stop_test();
    end
    // Whole run needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        stop_test();
    end
endmodule // audio_tx_status_flags_tb
bind audio_tx_status_flags tx_flags_monitor i_tx_flags_monitor (.*);
